// ==== rtl/ptr_pkg.sv ====
/*
 * constants for the trigger/time stamp register slice: offsets, strides, reset values.
 * assumes a 16-bit host register port with even byte addresses.
 */
package ptr_pkg;
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned UNITS = 12;
    localparam logic [10:0] ITER_HIGH_OFS = 11'h236;
    localparam logic [10:0] TRIG2_BASE = 11'h240;
    localparam logic [10:0] TRIG12_BASE = 11'h380;
    localparam logic [10:0] TRIG_STRIDE = 11'h020;
    localparam logic [10:0] TRIG_SET_LEN = 11'h018;
    localparam logic [10:0] TRIG2_CFG1_OFS = 11'h248;
    localparam logic [10:0] RSV_END = 11'h3ff;
    localparam logic [10:0] STAMP_BASE = 11'h400;
    localparam logic [10:0] STAMP_END = 11'h5ff;
    localparam logic [10:0] READY_OFS = 11'h400;
    localparam logic [10:0] ENABLE_OFS = 11'h402;
    localparam int unsigned EDGE_BIT = 7;
    localparam int unsigned SET_WORDS = 12;
    localparam logic [15:0] ITER_HIGH_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [11:0] READY_RST = 12'h000;
    localparam logic [11:0] ENABLE_RST = 12'h000;
    localparam logic [3:0] GPIO_PIN_ONE = 4'h0;
endpackage : ptr_pkg

// ==== rtl/ptr_regs.sv ====
/*
 * register slice of the ptp event block: trigger unit 1 iteration time high word,
 * register sets of trigger units 2..12, unit-2 output edge select, stamp ready flags.
 * assumes the host port gives one-cycle rd/wr strobes with an 11-bit even byte address;
 * capture events arrive as single-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps
module ptr_regs #(
    parameter int unsigned UNITS = ptr_pkg::UNITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host register port
    input wire logic [10:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic rd_hit,
    // trigger engine side
    input wire logic [31:0] trig1_target_time,
    output logic [31:0] trig1_next_time,
    output logic [15:0] iteration_time_high_reg,
    input wire logic [15:0] iteration_time_low,
    input wire logic [3:0] unit_two_pin_sel,
    input wire logic unit_two_out,
    output logic general_io_pin_one,
    output logic unit_two_fall_edge,
    // time stamp side
    input wire logic [UNITS-1:0] stamp_capture,
    input wire logic [UNITS-1:0] stamp_count_ovfl_set,
    input wire logic stamp_irq_enable,
    output logic [UNITS-1:0] stamp_unit_enable,
    output logic [UNITS-1:0] event_count_overflow_flag,
    output logic stamp_irq
);
    // trigger sets stored flat: index = (unit-2)*12 + word
    localparam int unsigned NSET = 11 * ptr_pkg::SET_WORDS;

    logic [15:0] iter_high_r, iter_high_nxt;
    logic [15:0] trig_mem_r [NSET];
    logic [UNITS-1:0] ready_r, ready_nxt;
    logic [UNITS-1:0] en_r, en_nxt;
    logic [UNITS-1:0] ovfl_r, ovfl_nxt;
    logic [15:0] rdata_nxt;
    logic hit_nxt;
    logic set_hit;
    logic [7:0] set_idx;

    // returns hit and flat word index for the replicated trigger sets
    function automatic logic [8:0] set_decode(input logic [10:0] a);
        logic [10:0] rel;
        logic [3:0] unit;
        logic [10:0] ofs;
        rel = a - ptr_pkg::TRIG2_BASE;
        unit = rel[8:5];
        ofs = {6'h00, rel[4:0]};
        set_decode = 9'h000;
        if (a >= ptr_pkg::TRIG2_BASE && a <= ptr_pkg::TRIG12_BASE + ptr_pkg::TRIG_SET_LEN - 11'h001
            && ofs < ptr_pkg::TRIG_SET_LEN) begin
            set_decode = {1'b1, 8'(unit * 4'd12 + {4'h0, ofs[4:1]})};
        end
    endfunction : set_decode

    assign {set_hit, set_idx} = set_decode(addr);

    always_comb begin
        iter_high_nxt = iter_high_r;
        en_nxt = en_r;
        rdata_nxt = 16'h0000;
        hit_nxt = 1'b0;
        if (wr && addr == ptr_pkg::ITER_HIGH_OFS) begin
            iter_high_nxt = wdata;
        end
        if (wr && addr == ptr_pkg::ENABLE_OFS) begin
            en_nxt = wdata[UNITS-1:0];
        end
        if (rd) begin
            if (addr == ptr_pkg::ITER_HIGH_OFS) begin
                rdata_nxt = iter_high_r;
                hit_nxt = 1'b1;
            end else if (set_hit) begin
                rdata_nxt = trig_mem_r[set_idx];
                hit_nxt = 1'b1;
            end else if (addr == ptr_pkg::READY_OFS) begin
                rdata_nxt = {4'h0, ready_r};
                hit_nxt = 1'b1;
            end else if (addr == ptr_pkg::ENABLE_OFS) begin
                rdata_nxt = {4'h0, en_r};
                hit_nxt = 1'b1;
            end
            // reserved gaps and the rest of the stamp space read zero
        end
    end

    // writing enable zero clears ready and overflow; a capture on the same edge loses
    always_comb begin
        for (int i = 0; i < UNITS; i++) begin
            ready_nxt[i] = ready_r[i] | (en_r[i] & stamp_capture[i]);
            ovfl_nxt[i] = ovfl_r[i] | (en_r[i] & stamp_count_ovfl_set[i]);
            if (!en_nxt[i]) begin
                ready_nxt[i] = 1'b0;
                ovfl_nxt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iter_high_r <= ptr_pkg::ITER_HIGH_RST;
            ready_r <= ptr_pkg::READY_RST;
            en_r <= ptr_pkg::ENABLE_RST;
            ovfl_r <= '0;
            rdata <= 16'h0000;
            rd_hit <= 1'b0;
            for (int i = 0; i < NSET; i++) begin
                trig_mem_r[i] <= ptr_pkg::CFG_RST;
            end
        end else begin
            iter_high_r <= iter_high_nxt;
            ready_r <= ready_nxt;
            en_r <= en_nxt;
            ovfl_r <= ovfl_nxt;
            rdata <= rdata_nxt;
            rd_hit <= hit_nxt;
            if (wr && set_hit) begin
                trig_mem_r[set_idx] <= wdata;
            end
        end
    end

    // unit-2 first config word sits at flat index 4
    assign unit_two_fall_edge = trig_mem_r[4][ptr_pkg::EDGE_BIT];
    assign iteration_time_high_reg = iter_high_r;
    // is software's; the sum simply wraps if it is broken
    assign trig1_next_time = trig1_target_time + {iter_high_r, iteration_time_low};

    // falling-edge launch copy of the unit-2 output
    logic fall_q_r;
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            fall_q_r <= 1'b0;
        end else begin
            fall_q_r <= unit_two_out;
        end
    end
    logic rise_q_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_q_r <= 1'b0;
        end else begin
            rise_q_r <= unit_two_out;
        end
    end
    // edge choice ignored unless unit 2 is routed to pin one
    assign general_io_pin_one = (unit_two_pin_sel == ptr_pkg::GPIO_PIN_ONE && unit_two_fall_edge)
        ? fall_q_r : rise_q_r;

    assign stamp_unit_enable = en_r;
    assign event_count_overflow_flag = ovfl_r;
    assign stamp_irq = stamp_irq_enable & (|ready_r);

    // flags may only live in enabled units; checked over the whole vector, not one bit
    ready_clr_a: assert property (@(posedge clk) disable iff (rst)
        (ready_r & ~en_r) == '0) else $error("ready set while disabled");
    ovfl_clr_a: assert property (@(posedge clk) disable iff (rst)
        (ovfl_r & ~en_r) == '0) else $error("overflow set while disabled");
    ready_set_a: assert property (@(posedge clk) disable iff (rst)
        en_r[0] && stamp_capture[0] && en_nxt[0] |=> ready_r[0])
        else $error("capture did not set ready");
    ready_hold_a: assert property (@(posedge clk) disable iff (rst)
        ready_r[0] && en_nxt[0] |=> ready_r[0]) else $error("ready dropped while enabled");

    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        stamp_irq == (stamp_irq_enable && ready_r != '0)) else $error("irq mismatch");
    iter_write_a: assert property (@(posedge clk) disable iff (rst)
        wr && addr == ptr_pkg::ITER_HIGH_OFS |=> iter_high_r == $past(wdata))
        else $error("iteration high not written");
    next_time_a: assert property (@(posedge clk) disable iff (rst)
        trig1_next_time == trig1_target_time + {iter_high_r, iteration_time_low})
        else $error("next time wrong");
    rsv_read_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr >= ptr_pkg::TRIG12_BASE + ptr_pkg::TRIG_SET_LEN && addr <= ptr_pkg::RSV_END
        |=> rdata == 16'h0000 && !rd_hit) else $error("reserved read nonzero");
    ready_top_a: assert property (@(posedge clk) disable iff (rst)
        rd && addr == ptr_pkg::READY_OFS |=> rdata[15:12] == 4'h0 && rd_hit)
        else $error("ready upper bits nonzero");
    en_clear_a: assert property (@(posedge clk) disable iff (rst)
        wr && addr == ptr_pkg::ENABLE_OFS && wdata[0] == 1'b0 |=> !ready_r[0] && !ovfl_r[0])
        else $error("disable did not clear flags");
    set_wr_a: assert property (@(posedge clk) disable iff (rst)
        wr && addr == ptr_pkg::TRIG12_BASE ##1 rd && addr == ptr_pkg::TRIG12_BASE
        |=> rdata == $past(wdata, 2)) else $error("unit 12 set not stored");
    edge_sel_a: assert property (@(posedge clk) disable iff (rst)
        unit_two_pin_sel != ptr_pkg::GPIO_PIN_ONE |-> general_io_pin_one == rise_q_r)
        else $error("edge select leaked");
    edge_fall_a: assert property (@(posedge clk) disable iff (rst)
        unit_two_pin_sel == ptr_pkg::GPIO_PIN_ONE && unit_two_fall_edge
        |-> general_io_pin_one == fall_q_r) else $error("falling launch not used");

    // main scenarios the bench is expected to reach
    ready_cov_c: cover property (@(posedge clk) disable iff (rst) ready_r[0] ##1 !ready_r[0]);
    irq_cov_c: cover property (@(posedge clk) disable iff (rst) $rose(stamp_irq));
    fall_cov_c: cover property (@(posedge clk) disable iff (rst)
        unit_two_fall_edge && unit_two_pin_sel == ptr_pkg::GPIO_PIN_ONE);
    set_wr_c: cover property (@(posedge clk) disable iff (rst)
        wr && set_hit ##1 rd && set_hit);
endmodule : ptr_regs

// ==== verif/tb_top.sv ====
/*
 * self-checking bench for ptr_regs: random and corner accesses through the host port.
 * assumes one-cycle rd/wr strobes and registered read data one cycle after rd.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, wr, rd, rd_hit, unit_out, pin_one, fall_edge, irq_en, irq;
    logic [10:0] addr, a;
    logic [15:0] wdata, rdata, iter_hi, iter_lo, v;
    logic [31:0] target, next_time;
    logic [3:0] pin_sel;
    logic [11:0] cap, ovfl_set, en, ovfl, exp_rdy, exp_ovfl, m;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    ptr_regs u_ptr_regs (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata), .rd_hit(rd_hit), .trig1_target_time(target),
        .trig1_next_time(next_time), .iteration_time_high_reg(iter_hi),
        .iteration_time_low(iter_lo), .unit_two_pin_sel(pin_sel), .unit_two_out(unit_out),
        .general_io_pin_one(pin_one), .unit_two_fall_edge(fall_edge), .stamp_capture(cap),
        .stamp_count_ovfl_set(ovfl_set), .stamp_irq_enable(irq_en), .stamp_unit_enable(en),
        .event_count_overflow_flag(ovfl), .stamp_irq(irq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            results();
        end
    end
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(logic [10:0] ad, logic [15:0] d);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        tick();
    endtask : wr_reg
    task automatic rd_chk(logic [10:0] ad, logic [15:0] exp, logic hit);
        addr = ad;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        check("rdata", exp, rdata);
        check("rd_hit", hit, rd_hit);
        tick();
    endtask : rd_chk
    // changes the unit-2 waveform after a rising edge and looks just past the falling one
    task automatic pin_chk(logic fe);
        logic old;
        old = unit_out;
        unit_out = 1'($urandom);
        pin_sel = 4'($urandom_range(0, 1) * $urandom_range(1, 15));
        #2;
        check("pin_one", (pin_sel == ptr_pkg::GPIO_PIN_ONE && fe) ? unit_out : old, pin_one);
    endtask : pin_chk
    task automatic results();
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        {wr, rd, addr, wdata, irq_en, pin_sel, unit_out, cap, ovfl_set, target, iter_lo} = '0;
        rst = 1'b1;
        v = 16'($urandom(50));
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_chk(11'h236, 16'h0000, 1'b1);
        rd_chk(11'h400, 16'h0000, 1'b1);
        for (int i = 0; i < 8; i++) begin
            // a nonzero high word keeps the cycle time above any waveform product
            v = 16'($urandom) | 16'h0001;
            target = $urandom;
            iter_lo = 16'($urandom);
            wr_reg(11'h236, v);
            rd_chk(11'h236, v, 1'b1);
            check("next_time", target + {v, iter_lo}, next_time);
        end
        // one random word per unit set plus a gap word, which must stay unimplemented
        for (int u = 0; u < 11; u++) begin
            a = 11'(ptr_pkg::TRIG2_BASE + ptr_pkg::TRIG_STRIDE * u + 2 * $urandom_range(0, 11));
            v = 16'($urandom);
            wr_reg(a, v);
            rd_chk(a, v, 1'b1);
            a = 11'(ptr_pkg::TRIG2_BASE + ptr_pkg::TRIG_STRIDE * u + 11'h018 + 2 * (u % 4));
            wr_reg(a, 16'hffff);
            rd_chk(a, 16'h0000, 1'b0);
        end
        // back-to-back write and read of the last set
        v = 16'($urandom);
        addr = ptr_pkg::TRIG12_BASE;
        wdata = v;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        check("rdata", v, rdata);
        tick();
        wr_reg(11'h3fe, 16'hffff);
        rd_chk(11'h3fe, 16'h0000, 1'b0);
        rd_chk(11'h238, 16'h0000, 1'b0);
        wr_reg(11'h248, 16'h0080);
        check("fall_edge", 1'b1, fall_edge);
        irq_en = 1'b1;
        wr_reg(11'h402, 16'h0fff);
        rd_chk(11'h402, 16'h0fff, 1'b1);
        exp_rdy = '0;
        exp_ovfl = '0;
        repeat (20) begin
            cap = 12'($urandom & $urandom & $urandom);
            ovfl_set = 12'($urandom);
            pin_chk(1'b1);
            tick();
            exp_rdy |= cap;
            exp_ovfl |= ovfl_set;
            check("stamp_irq", |exp_rdy, irq);
        end
        cap = '0;
        ovfl_set = '0;
        check("ovfl", exp_ovfl, ovfl);
        wr_reg(11'h248, 16'h0000);
        check("fall_edge", 1'b0, fall_edge);
        repeat (4) begin
            pin_chk(1'b0);
            tick();
        end
        wr_reg(11'h400, 16'hffff);
        rd_chk(11'h400, {4'h0, exp_rdy}, 1'b1);
        m = 12'($urandom);
        wr_reg(11'h402, {4'h0, m});
        exp_rdy &= m;
        check("ovfl_cleared", 12'h000, ovfl & ~m);
        check("ovfl_kept", exp_ovfl & m, ovfl);
        cap = ~m;
        tick();
        cap = '0;
        rd_chk(11'h400, {4'h0, exp_rdy}, 1'b1);
        irq_en = 1'b0;
        tick();
        check("stamp_irq", 1'b0, irq);
        results();
    end
endmodule : tb_top
